// >>> ffmt_detect.sv
// Freefall/motion threshold compare and debounce counter with its registers.
// Assumes the serial interface presents single-cycle register reads and writes,
// and that axis samples arrive as signed words in threshold count units.
`include "ffmt_map.svh"
module ffmt_detect
  import ffmt_pkg::*;
#(
  parameter int unsigned BASE_CYCLES = `BASE_STEP_PS / `CLK_PERIOD_PS
)(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire byte_t       reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output byte_t            reg_rdata,
  input  wire logic        sample_valid,
  input  wire logic [13:0] x_sample,
  input  wire logic [13:0] y_sample,
  input  wire logic [13:0] z_sample,
  input  wire logic [2:0]  axis_enable,
  input  wire logic        or_above_mode,
  input  wire rate_sel_t   rate_select,
  input  wire osr_mode_t   osr_mode,
  input  wire logic        hybrid_mode,
  output logic             event_flag,
  output byte_t            debounce_count
);
  // ==========================================================
  // Registers
  byte_t shared_threshold;
  byte_t motion_debounce_limit;
  byte_t x_threshold_high;
  byte_t x_threshold_low;
  byte_t y_threshold_high;
  byte_t y_threshold_low;
  byte_t z_threshold_high;
  byte_t z_threshold_low;
  byte_t next_shared_threshold;
  byte_t next_motion_debounce_limit;
  byte_t next_x_threshold_high;
  byte_t next_x_threshold_low;
  byte_t next_y_threshold_high;
  byte_t next_y_threshold_low;
  byte_t next_z_threshold_high;
  byte_t next_z_threshold_low;
  byte_t next_reg_rdata;

  always_comb
  begin
    next_shared_threshold      = shared_threshold;
    next_motion_debounce_limit = motion_debounce_limit;
    next_x_threshold_high      = x_threshold_high;
    next_x_threshold_low       = x_threshold_low;
    next_y_threshold_high      = y_threshold_high;
    next_y_threshold_low       = y_threshold_low;
    next_z_threshold_high      = z_threshold_high;
    next_z_threshold_low       = z_threshold_low;
    if (reg_wr)
    begin
      case (reg_addr)
        `OFS_SHARED_THRESHOLD: next_shared_threshold      = reg_wdata;
        `OFS_DEBOUNCE_LIMIT:   next_motion_debounce_limit = reg_wdata;
        `OFS_X_THRESHOLD_HIGH: next_x_threshold_high      = reg_wdata;
        `OFS_X_THRESHOLD_LOW:  next_x_threshold_low       = reg_wdata;
        `OFS_Y_THRESHOLD_HIGH: next_y_threshold_high      = reg_wdata;
        `OFS_Y_THRESHOLD_LOW:  next_y_threshold_low       = reg_wdata;
        `OFS_Z_THRESHOLD_HIGH: next_z_threshold_high      = reg_wdata;
        `OFS_Z_THRESHOLD_LOW:  next_z_threshold_low       = reg_wdata;
        default:               next_shared_threshold      = shared_threshold;
      endcase
    end
    next_reg_rdata = reg_rdata;
    if (reg_rd)
    begin
      case (reg_addr)
        `OFS_SHARED_THRESHOLD: next_reg_rdata = shared_threshold;
        `OFS_DEBOUNCE_LIMIT:   next_reg_rdata = motion_debounce_limit;
        `OFS_X_THRESHOLD_HIGH: next_reg_rdata = x_threshold_high;
        `OFS_X_THRESHOLD_LOW:  next_reg_rdata = x_threshold_low;
        `OFS_Y_THRESHOLD_HIGH: next_reg_rdata = y_threshold_high;
        `OFS_Y_THRESHOLD_LOW:  next_reg_rdata = y_threshold_low;
        `OFS_Z_THRESHOLD_HIGH: next_reg_rdata = z_threshold_high;
        `OFS_Z_THRESHOLD_LOW:  next_reg_rdata = z_threshold_low;
        default:               next_reg_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      shared_threshold      <= `REG_RESET;
      motion_debounce_limit <= `REG_RESET;
      x_threshold_high      <= `REG_RESET;
      x_threshold_low       <= `REG_RESET;
      y_threshold_high      <= `REG_RESET;
      y_threshold_low       <= `REG_RESET;
      z_threshold_high      <= `REG_RESET;
      z_threshold_low       <= `REG_RESET;
      reg_rdata             <= 8'h00;
    end
    else
    begin
      shared_threshold      <= next_shared_threshold;
      motion_debounce_limit <= next_motion_debounce_limit;
      x_threshold_high      <= next_x_threshold_high;
      x_threshold_low       <= next_x_threshold_low;
      y_threshold_high      <= next_y_threshold_high;
      y_threshold_low       <= next_y_threshold_low;
      z_threshold_high      <= next_z_threshold_high;
      z_threshold_low       <= next_z_threshold_low;
      reg_rdata             <= next_reg_rdata;
    end
  end

  // ==========================================================
  // Threshold selection and per-axis compare
  logic        per_axis_en;
  logic        clear_mode;
  logic [13:0] samples  [3];
  byte_t       th_high  [3];
  byte_t       th_low   [3];
  logic [2:0]  below;
  logic [2:0]  above;
  logic        match;

  assign per_axis_en = x_threshold_high[`BIT_PER_AXIS_EN];
  assign clear_mode  = shared_threshold[`BIT_CLEAR_MODE];
  assign samples[0]  = x_sample;
  assign samples[1]  = y_sample;
  assign samples[2]  = z_sample;
  assign th_high[0]  = x_threshold_high;
  assign th_high[1]  = y_threshold_high;
  assign th_high[2]  = z_threshold_high;
  assign th_low[0]   = x_threshold_low;
  assign th_low[1]   = y_threshold_low;
  assign th_low[2]   = z_threshold_low;

  for (genvar a = 0; a < 3; a++)
  begin : g_axis
    logic [13:0] magnitude;
    thresh_t     limit;
    // Negating the most negative code wraps, so it is pinned to full scale
    assign magnitude = !samples[a][13] ? samples[a]
                     : (samples[a] == 14'h2000) ? 14'h1FFF
                     : 14'(-samples[a]);
    // 13-bit value rebuilt from high and low
    assign limit = per_axis_en ? {th_high[a][6:0], th_low[a][7:2]}
                               : {6'h00, shared_threshold[6:0]};
    assign below[a] = !axis_enable[a] || (magnitude < {1'b0, limit});
    assign above[a] = axis_enable[a] && (magnitude > {1'b0, limit});
  end

  // all below, any above; no enabled axis never matches
  assign match = (axis_enable != 3'h0) && (or_above_mode ? (|above) : (&below));

  // ==========================================================
  // Debounce step from rate, oversampling and hybrid mode
  step_mult_t base_mult;
  step_mult_t step_mult;
  logic       step_tick;

  always_comb
  begin
    // 800 and 400 Hz are common to all oversampling modes; hybrid mode doubles them
    case (rate_select)
      3'h0:    base_mult = `MULT_1;
      3'h1:    base_mult = `MULT_2;
      3'h2:    base_mult = `MULT_4;
      3'h3:    base_mult = `MULT_8;
      3'h4:    base_mult = `MULT_16;
      3'h5:    base_mult = `MULT_64;
      default: base_mult = `MULT_128;
    endcase
    case (osr_mode)
      OSR_HIGH_RES:  step_mult = (base_mult > `MULT_2) ? `MULT_2 : base_mult;
      OSR_NORMAL:    step_mult = (base_mult > `MULT_16) ? `MULT_16 : base_mult;
      OSR_LOW_NOISE: step_mult = (base_mult > `MULT_64) ? `MULT_64 : base_mult;
      default:       step_mult = base_mult;
    endcase
    if (hybrid_mode)
    begin
      step_mult = step_mult << 1;
    end
  end

  step_timer #(
    .BASE_CYCLES (BASE_CYCLES)
  ) u_step_timer (
    .core_clk  (core_clk),
    .rst       (rst),
    .mult      (step_mult),
    .step_tick (step_tick)
  );

  // ==========================================================
  // Sample latch and debounce counter
  logic  pending;
  logic  held_match;
  logic  next_pending;
  logic  next_held_match;
  logic  next_event_flag;
  byte_t next_debounce_count;

  always_comb
  begin
    next_pending        = pending;
    next_held_match     = held_match;
    next_debounce_count = debounce_count;
    next_event_flag     = event_flag;
    // consume the newest sample once per step
    if (step_tick && pending)
    begin
      next_pending = 1'b0;
      if (held_match)
      begin
        if (debounce_count < motion_debounce_limit)
        begin
          next_debounce_count = debounce_count + 8'h01;
        end
        else
        begin
          next_debounce_count = motion_debounce_limit;
        end
      end
      else if (clear_mode)
      begin
        next_debounce_count = 8'h00;
      end
      else if (debounce_count != 8'h00)
      begin
        next_debounce_count = debounce_count - 8'h01;
      end
      next_event_flag = held_match && (next_debounce_count == motion_debounce_limit);
    end
    // A sample arriving with the step is kept for the next step
    if (sample_valid)
    begin
      next_pending    = 1'b1;
      next_held_match = match;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pending        <= 1'b0;
      held_match     <= 1'b0;
      debounce_count <= 8'h00;
      event_flag     <= 1'b0;
    end
    else
    begin
      pending        <= next_pending;
      held_match     <= next_held_match;
      debounce_count <= next_debounce_count;
      event_flag     <= next_event_flag;
    end
  end
endmodule // ffmt_detect

// >>> ffmt_detect_monitor.sv
// Checker for ffmt_detect: debounce count, event flag and register reads.
// Assumes it is bound to ffmt_detect and sees only that module's ports.
module ffmt_detect_monitor
  import ffmt_pkg::*;
#(
  parameter int unsigned BASE_CYCLES = 4
)(
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic [7:0]  reg_addr,
  input wire byte_t       reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire byte_t       reg_rdata,
  input wire logic        sample_valid,
  input wire logic [13:0] x_sample,
  input wire logic [13:0] y_sample,
  input wire logic [13:0] z_sample,
  input wire logic [2:0]  axis_enable,
  input wire logic        or_above_mode,
  input wire rate_sel_t   rate_select,
  input wire osr_mode_t   osr_mode,
  input wire logic        hybrid_mode,
  input wire logic        event_flag,
  input wire byte_t       debounce_count
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // Shadow of written limit and threshold
  byte_t      lim;
  byte_t      shr;
  logic [15:0] gap;
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      lim <= 8'h00;
      shr <= 8'h00;
      gap <= 16'hFFFF;
    end
    else
    begin
      if (reg_wr && reg_addr == 8'h17)
        shr <= reg_wdata;
      if (reg_wr && reg_addr == 8'h18)
        lim <= reg_wdata;
      // Saturate so a long idle spell never wraps
      if ($changed(debounce_count))
        gap <= 16'h0000;
      else if (gap != 16'hFFFF)
        gap <= gap + 16'h0001;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_flag; event_flag |-> debounce_count == lim; endproperty
  a_flag: assert property (p_flag) else $error("flag away from limit");
  property p_sat; $changed(debounce_count) |-> debounce_count <= lim; endproperty
  a_sat: assert property (p_sat) else $error("count past limit");
  property p_up; debounce_count > $past(debounce_count) |->
    debounce_count == $past(debounce_count) + 8'h01; endproperty
  a_up: assert property (p_up) else $error("count jumped up");
  property p_zero; shr[7] && debounce_count < $past(debounce_count) |->
    debounce_count == 8'h00; endproperty
  a_zero: assert property (p_zero) else $error("count not cleared");
  property p_dec; !shr[7] && debounce_count < $past(debounce_count) |->
    debounce_count == $past(debounce_count) - 8'h01; endproperty
  a_dec: assert property (p_dec) else $error("count not decremented");
  property p_gap; $changed(debounce_count) |-> gap >= BASE_CYCLES - 1; endproperty
  a_gap: assert property (p_gap) else $error("count moved twice in a step");
  property p_rlim; reg_rd && !reg_wr && reg_addr == 8'h18 |=> reg_rdata == lim; endproperty
  a_rlim: assert property (p_rlim) else $error("limit read wrong");
  property p_rthr; reg_rd && !reg_wr && reg_addr == 8'h17 |=> reg_rdata == shr; endproperty
  a_rthr: assert property (p_rthr) else $error("threshold read wrong");
endmodule // ffmt_detect_monitor

bind ffmt_detect ffmt_detect_monitor #(.BASE_CYCLES(BASE_CYCLES)) mon (.core_clk, .rst,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sample_valid, .x_sample,
  .y_sample, .z_sample, .axis_enable, .or_above_mode, .rate_select, .osr_mode,
  .hybrid_mode, .event_flag, .debounce_count);

// >>> ffmt_host.sv
// Host model: register writes and reads, one strobe each.
// Assumes the bench calls wr and rd; drives at falling edges.
module ffmt_host
  import ffmt_pkg::*;
(
  input  wire logic  core_clk,
  input  wire byte_t reg_rdata,
  output logic [7:0] reg_addr,
  output byte_t      reg_wdata,
  output logic       reg_wr,
  output logic       reg_rd
);
  timeunit 1ns;
  timeprecision 1ns;
  logic pax = 1'h0;
  logic tse = 1'h0;
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
  end
  task automatic wr(input logic [7:0] a, input byte_t d);
    byte_t v;
    v = d;
    if (a == 8'h75 && pax)
      v[7] = 1'h0;
    if (a == 8'h73 && tse)
      v[7] = 1'h0;
    if (a == 8'h73)
      pax = v[7];
    if (a == 8'h75)
      tse = v[7];
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'h1;
    @(negedge core_clk);
    reg_wr = 1'h0;
    reg_addr = ~a;
    reg_wdata = ~v;
  endtask
  task automatic rd(input logic [7:0] a, output byte_t d);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'h1;
    @(negedge core_clk);
    reg_rd = 1'h0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask
endmodule // ffmt_host

// >>> ffmt_map.svh
// Register offsets, field positions, reset values and timing counts
// for the freefall/motion threshold and debounce block.
// Assumes an 8-bit register port behind the serial interface.
`ifndef FFMT_MAP_SVH
`define FFMT_MAP_SVH

// ==========================================================
// Register offsets
`define OFS_SHARED_THRESHOLD   8'h17
`define OFS_DEBOUNCE_LIMIT     8'h18
`define OFS_X_THRESHOLD_HIGH   8'h73
`define OFS_X_THRESHOLD_LOW    8'h74
`define OFS_Y_THRESHOLD_HIGH   8'h75
`define OFS_Y_THRESHOLD_LOW    8'h76
`define OFS_Z_THRESHOLD_HIGH   8'h77
`define OFS_Z_THRESHOLD_LOW    8'h78

// ==========================================================
// Field positions and reset value
`define BIT_CLEAR_MODE         7
`define BIT_PER_AXIS_EN        7
`define BIT_TRANS_SHARE_EN     7
`define REG_RESET              8'h00

// ==========================================================
// Timing: base step and multipliers of it
`define CLK_PERIOD_PS          100000
`define BASE_STEP_PS           1250000000
`define MULT_1                 9'h001
`define MULT_2                 9'h002
`define MULT_4                 9'h004
`define MULT_8                 9'h008
`define MULT_16                9'h010
`define MULT_64                9'h040
`define MULT_128               9'h080

`endif

// >>> ffmt_pkg.sv
// Types shared by the freefall/motion block and its step timer.
// Assumes the rate and oversampling selections come from the rate control register.
package ffmt_pkg;
  typedef logic [7:0]  byte_t;
  typedef logic [12:0] thresh_t;
  typedef logic [2:0]  rate_sel_t;   // 0=800 Hz ... 7=1.56 Hz
  typedef logic [8:0]  step_mult_t;
  typedef enum logic [1:0] {OSR_NORMAL, OSR_LOW_NOISE, OSR_HIGH_RES, OSR_LOW_POWER} osr_mode_t;
endpackage

// >>> freefall_motion_threshold_debounce_bench.sv
// Self-checking bench for ffmt_detect with a short base step.
// Assumes ffmt_host for register traffic and the bound checker.
module freefall_motion_threshold_debounce_bench
  import ffmt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned BC = 4;
  typedef struct {logic [13:0] x, y, z; logic [2:0] en; logic md, m;} row_t;
  typedef struct {rate_sel_t r; osr_mode_t o; logic h; logic [8:0] m;} tim_t;
  logic        core_clk, rst, reg_wr, reg_rd, sample_valid, or_above_mode;
  logic        hybrid_mode, event_flag, clr;
  logic [7:0]  reg_addr;
  byte_t       reg_wdata, reg_rdata, debounce_count, lim, exp, d;
  logic [13:0] x_sample, y_sample, z_sample;
  logic [2:0]  axis_enable;
  rate_sel_t   rate_select;
  osr_mode_t   osr_mode;
  int          num_errors = 0;
  int          n_tests = 0;
  int          n;
  logic [7:0]  ad [8] = '{8'h17, 8'h18, 8'h73, 8'h74, 8'h75, 8'h76, 8'h77, 8'h78};
  // Shared threshold 10: low-g rows then high-g rows
  row_t rows [8] = '{'{14'h0005, 14'h3FFB, 14'h0009, 3'h7, 1'h0, 1'h1},
    '{14'h0005, 14'h3FF6, 14'h0000, 3'h7, 1'h0, 1'h0},
    '{14'h0005, 14'h3FF6, 14'h0000, 3'h5, 1'h0, 1'h1},
    '{14'h0000, 14'h0000, 14'h0000, 3'h0, 1'h0, 1'h0},
    '{14'h000B, 14'h0000, 14'h0000, 3'h7, 1'h1, 1'h1},
    '{14'h000A, 14'h3FF6, 14'h000A, 3'h7, 1'h1, 1'h0},
    '{14'h0000, 14'h0000, 14'h3FF5, 3'h3, 1'h1, 1'h0},
    '{14'h0000, 14'h0000, 14'h3FF5, 3'h7, 1'h1, 1'h1}};
  tim_t tr [10] = '{'{3'h0, OSR_LOW_POWER, 1'h0, 9'h001},
    '{3'h1, OSR_HIGH_RES, 1'h0, 9'h002}, '{3'h2, OSR_NORMAL, 1'h0, 9'h004},
    '{3'h3, OSR_NORMAL, 1'h0, 9'h008}, '{3'h4, OSR_NORMAL, 1'h0, 9'h010},
    '{3'h5, OSR_NORMAL, 1'h0, 9'h010}, '{3'h5, OSR_LOW_NOISE, 1'h0, 9'h040},
    '{3'h6, OSR_LOW_POWER, 1'h0, 9'h080}, '{3'h7, OSR_HIGH_RES, 1'h0, 9'h002},
    '{3'h2, OSR_LOW_POWER, 1'h1, 9'h008}};
  ffmt_host host (.core_clk, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
  ffmt_detect #(.BASE_CYCLES(BC)) dut (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .sample_valid, .x_sample, .y_sample, .z_sample, .axis_enable,
    .or_above_mode, .rate_select, .osr_mode, .hybrid_mode, .event_flag, .debounce_count);
  // ==========================================
  // Checks and stimulus tasks
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", s, e, g);
    end
  endtask
  // Wait covers one full step plus the update cycle
  task automatic step(input row_t r);
    @(negedge core_clk);
    {x_sample, y_sample, z_sample} = {r.x, r.y, r.z};
    {axis_enable, or_above_mode, sample_valid} = {r.en, r.md, 1'h1};
    @(negedge core_clk);
    sample_valid = 1'h0;
    repeat (BC + 2) @(negedge core_clk);
    if (r.m)
      exp = (exp < lim) ? exp + 8'h01 : exp;
    else
      exp = clr ? 8'h00 : ((exp != 8'h00) ? exp - 8'h01 : exp);
    chk("count", 16'(exp), 16'(debounce_count));
    chk("flag", 16'(r.m && exp == lim), 16'(event_flag));
  endtask
  task automatic wchg(output int c);
    byte_t v;
    v = debounce_count;
    c = 0;
    while (debounce_count === v && c < 3000)
    begin
      @(negedge core_clk);
      c++;
    end
  endtask
  task automatic complete_run;
    if (num_errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    core_clk = 1'h0;
    forever #50 core_clk = ~core_clk;
  end
  initial
  begin
    #2000000;
    num_errors++;
    complete_run;
  end
  initial
  begin
    {sample_valid, x_sample, y_sample, z_sample} = '0;
    rst = 1'h1;
    {axis_enable, or_above_mode, rate_select, hybrid_mode} = '0;
    osr_mode = OSR_NORMAL;
    exp = 8'h00;
    repeat (5) @(negedge core_clk);
    rst = 1'h0;
    foreach (ad[i])
    begin
      host.rd(ad[i], d);
      chk("reset", 16'h0000, 16'(d));
      host.wr(ad[i], ad[i] ^ 8'h3C);
      host.rd(ad[i], d);
      chk("readback", 16'(ad[i] ^ 8'h3C), 16'(d));
    end
    host.rd(8'h20, d);
    chk("unmapped", 16'h0000, 16'(d));
    {lim, clr} = {8'hC8, 1'h1};
    host.wr(8'h18, lim);
    host.wr(8'h17, 8'h8A);
    foreach (rows[i])
      step(rows[i]);
    // Per-axis thresholds 65, 4096 and 2 with unused low bits set on x
    host.wr(8'h73, 8'h81);
    host.wr(8'h74, 8'h07);
    host.wr(8'h75, 8'h40);
    host.wr(8'h76, 8'h00);
    host.wr(8'h77, 8'h00);
    host.wr(8'h78, 8'h08);
    step('{14'h0042, 14'h0000, 14'h0000, 3'h7, 1'h1, 1'h1});
    step('{14'h0041, 14'h1000, 14'h0002, 3'h7, 1'h1, 1'h0});
    step('{14'h0000, 14'h0000, 14'h3FFD, 3'h7, 1'h1, 1'h1});
    step('{14'h0040, 14'h0FFF, 14'h0001, 3'h7, 1'h0, 1'h1});
    host.wr(8'h73, 8'h01);
    {lim, clr} = {8'h03, 1'h0};
    host.wr(8'h18, lim);
    host.wr(8'h17, 8'h0A);
    for (int i = 0; i < 7; i++)
      step(rows[i < 3 ? 0 : 1]);
    {lim, clr} = {8'hC8, 1'h1};
    host.wr(8'h18, lim);
    host.wr(8'h17, 8'h8A);
    @(negedge core_clk);
    {x_sample, axis_enable, or_above_mode, sample_valid} = {14'h000B, 3'h7, 1'h1, 1'h1};
    foreach (tr[i])
    begin
      rate_select = tr[i].r;
      osr_mode = tr[i].o;
      hybrid_mode = tr[i].h;
      wchg(n);
      wchg(n);
      wchg(n);
      chk("period", 16'(tr[i].m * BC), 16'(n));
    end
    // Mid-run reset must clear count, flag, read data and the limit register
    host.rd(8'h17, d);
    chk("threshold", 16'h008A, 16'(d));
    @(negedge core_clk);
    sample_valid = 1'h0;
    rst = 1'h1;
    repeat (2) @(negedge core_clk);
    rst = 1'h0;
    chk("reset count", 16'h0000, 16'(debounce_count));
    chk("reset flag", 16'h0000, 16'(event_flag));
    chk("reset rdata", 16'h0000, 16'(reg_rdata));
    host.rd(8'h18, d);
    chk("reset limit", 16'h0000, 16'(d));
    complete_run;
  end
endmodule // freefall_motion_threshold_debounce_bench

// >>> step_timer.sv
// Debounce step tick generator: one-cycle pulse every mult base steps.
// Assumes mult is at least 1; a change of mult applies to the step in progress, at its next base step.
`include "ffmt_map.svh"
module step_timer
  import ffmt_pkg::*;
#(
  parameter int unsigned BASE_CYCLES = `BASE_STEP_PS / `CLK_PERIOD_PS
)(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire step_mult_t mult,
  output logic            step_tick
);
  logic [23:0] base_cnt;
  logic [23:0] next_base_cnt;
  step_mult_t  mult_cnt;
  step_mult_t  next_mult_cnt;
  logic        next_step_tick;

  // ==========================================================
  // Divider
  always_comb
  begin
    next_base_cnt  = base_cnt + 24'h000001;
    next_mult_cnt  = mult_cnt;
    next_step_tick = 1'b0;
    if (base_cnt >= 24'(BASE_CYCLES - 1))
    begin
      next_base_cnt = 24'h000000;
      // Counting up to mult, so a shrinking mult still ends the step
      if (mult_cnt + 9'h001 >= mult)
      begin
        next_mult_cnt  = 9'h000;
        next_step_tick = 1'b1;
      end
      else
      begin
        next_mult_cnt = mult_cnt + 9'h001;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      base_cnt  <= 24'h000000;
      mult_cnt  <= 9'h000;
      step_tick <= 1'b0;
    end
    else
    begin
      base_cnt  <= next_base_cnt;
      mult_cnt  <= next_mult_cnt;
      step_tick <= next_step_tick;
    end
  end
endmodule // step_timer
